//--- rtl/pfb_pkg.sv
// package: constants, types and helpers for the parallel flash host controller
package pfb_pkg;

  // bus geometry
  localparam int ADDR_W   = 22;
  localparam int DATA_W   = 16;
  localparam int SECT_W   = 7;
  localparam int SECT_LSB = 15;
  localparam int CNT_W    = 16;

  // clock
  localparam int CLK_PERIOD_NS = 100;

  // pin timing, in ns
  localparam int RESET_PULSE_MIN_NS       = 500;
  localparam int RESET_TO_READ_DELAY_NS   = 50;
  localparam int SELECT_ACCESS_TIME_NS    = 90;
  localparam int ADDRESS_ACCESS_TIME_NS   = 90;
  localparam int WRITE_PULSE_NS           = 35;
  localparam int ACC_SETUP_NS             = 250;
  localparam int BUSY_VALID_NS            = 90;

  // two flops in front of every pin input
  localparam int SYNC_LAT = 2;

  // pins are registered, so select moves one edge after the take
  localparam int PIN_LAT = 1;

  // first cycle of the shortcut two-cycle program
  localparam logic [DATA_W-1:0] SHORTCUT_PROG_CMD = 16'h00A0;

  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;

  typedef enum logic [1:0] {
    PFB_OP_READ     = 2'h0,
    PFB_OP_WRITE    = 2'h1,
    PFB_OP_ACC_PROG = 2'h2,
    PFB_OP_RESET    = 2'h3
  } pfb_op_e;

  typedef struct packed {
    pfb_op_e           op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pfb_req_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
    logic              dq_oe_n;
    logic              select_n;
    logic              out_gate_n;
    logic              write_n;
    logic              reset_n;
    logic              fast_program_supply;
  } pfb_pins_s;

  // least time rounds up, never under one cycle
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic logic [SECT_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:SECT_LSB];
  endfunction

endpackage

//--- rtl/pfb_host.sv
// host-side controller that drives a parallel NOR flash through its pins

module pfb_host #(
  parameter int RESET_PULSE_MIN_NS     = pfb_pkg::RESET_PULSE_MIN_NS,
  parameter int RESET_TO_READ_DELAY_NS = pfb_pkg::RESET_TO_READ_DELAY_NS,
  parameter int SELECT_ACCESS_TIME_NS  = pfb_pkg::SELECT_ACCESS_TIME_NS,
  parameter int WRITE_PULSE_NS         = pfb_pkg::WRITE_PULSE_NS,
  parameter int ACC_SETUP_NS           = pfb_pkg::ACC_SETUP_NS,
  parameter int BUSY_VALID_NS          = pfb_pkg::BUSY_VALID_NS
) (
  // clock and reset
  input  wire logic                          clk_in,
  input  wire logic                          rst_in,
  // request side
  input  wire logic                          req_valid_in,
  input  wire pfb_pkg::pfb_req_s             req_in,
  output logic                               req_ready_out,
  // answer side
  output logic                               resp_valid_out,
  output logic [pfb_pkg::DATA_W-1:0]         resp_data_out,
  output logic                               restart_needed_out,
  output logic                               device_busy_out,
  output logic [pfb_pkg::SECT_W-1:0]         sector_out,
  // flash pins
  output pfb_pkg::pfb_pins_s                 pins_out,
  input  wire logic [pfb_pkg::DATA_W-1:0]    dq_in,
  input  wire logic                          done_indicator_n_in
);

  localparam logic [pfb_pkg::CNT_W-1:0] RST_LOW_CYC =
    pfb_pkg::CNT_W'(pfb_pkg::ns_to_cyc(RESET_PULSE_MIN_NS));
  localparam logic [pfb_pkg::CNT_W-1:0] RST_READ_CYC =
    pfb_pkg::CNT_W'(pfb_pkg::ns_to_cyc(RESET_TO_READ_DELAY_NS));
  localparam logic [pfb_pkg::CNT_W-1:0] READ_CYC =
    pfb_pkg::CNT_W'(pfb_pkg::ns_to_cyc(SELECT_ACCESS_TIME_NS) + pfb_pkg::PIN_LAT +
                    pfb_pkg::SYNC_LAT);
  localparam logic [pfb_pkg::CNT_W-1:0] WR_PULSE_CYC =
    pfb_pkg::CNT_W'(pfb_pkg::ns_to_cyc(WRITE_PULSE_NS));
  localparam logic [pfb_pkg::CNT_W-1:0] ACC_CYC =
    pfb_pkg::CNT_W'(pfb_pkg::ns_to_cyc(ACC_SETUP_NS));
  localparam logic [pfb_pkg::CNT_W-1:0] BUSY_CYC =
    pfb_pkg::CNT_W'(pfb_pkg::ns_to_cyc(BUSY_VALID_NS) + pfb_pkg::SYNC_LAT);

  typedef enum logic [8:0] {
    ST_IDLE     = 9'h001,
    ST_ACC_RAMP = 9'h002,
    ST_WR_SETUP = 9'h004,
    ST_WR_PULSE = 9'h008,
    ST_WR_HOLD  = 9'h010,
    ST_RD_WAIT  = 9'h020,
    ST_BUSY     = 9'h040,
    ST_RST_LOW  = 9'h080,
    ST_RST_WAIT = 9'h100
  } pfb_state_e;

  pfb_state_e                  state;
  logic [pfb_pkg::CNT_W-1:0]   cnt;
  logic                        beat;
  pfb_pkg::pfb_req_s           cur;
  logic                        rdy_meta;
  logic                        rdy_sync;
  logic [pfb_pkg::DATA_W-1:0]  dq_meta;
  logic [pfb_pkg::DATA_W-1:0]  dq_sync;
  logic                        accept;
  logic                        cnt_done;

  localparam logic [pfb_pkg::CNT_W-1:0] CNT_ONE_L = pfb_pkg::CNT_ONE;

  assign req_ready_out = (state == ST_IDLE);
  assign accept        = req_valid_in && req_ready_out;
  assign cnt_done      = (cnt == CNT_ONE_L);

  ////////////////////////////////////////////////////////////////////////////
  // pin input synchronisers
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rdy_meta <= 1'b1;
      rdy_sync <= 1'b1;
      dq_meta  <= '0;
      dq_sync  <= '0;
    end
    else
    begin
      rdy_meta <= done_indicator_n_in;
      rdy_sync <= rdy_meta;
      dq_meta  <= dq_in;
      dq_sync  <= dq_meta;
    end
  end

  assign device_busy_out = ~rdy_sync;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state <= ST_IDLE;
      cnt   <= pfb_pkg::CNT_ZERO;
      beat  <= 1'b0;
      cur   <= '0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          beat <= 1'b0;
          if (accept)
          begin
            cur <= req_in;
            case (req_in.op)
              pfb_pkg::PFB_OP_READ:
              begin
                state <= ST_RD_WAIT;
                cnt   <= READ_CYC;
              end
              pfb_pkg::PFB_OP_WRITE:
                state <= ST_WR_SETUP;
              pfb_pkg::PFB_OP_ACC_PROG:
              begin
                state <= ST_ACC_RAMP;
                cnt   <= ACC_CYC;
              end
              pfb_pkg::PFB_OP_RESET:
              begin
                state <= ST_RST_LOW;
                cnt   <= RST_LOW_CYC;
              end
              default:
                state <= ST_IDLE;
            endcase
          end
        end
        ST_ACC_RAMP:
        begin
          cnt <= cnt - CNT_ONE_L;
          if (cnt_done)
            state <= ST_WR_SETUP;
        end
        ST_WR_SETUP:
        begin
          state <= ST_WR_PULSE;
          cnt   <= WR_PULSE_CYC;
        end
        ST_WR_PULSE:
        begin
          cnt <= cnt - CNT_ONE_L;
          if (cnt_done)
            state <= ST_WR_HOLD;
        end
        ST_WR_HOLD:
        begin
          // accelerated program: shortcut code beat, then data beat
          if (cur.op == pfb_pkg::PFB_OP_ACC_PROG && !beat)
          begin
            beat  <= 1'b1;
            state <= ST_WR_SETUP;
          end
          else if (cur.op == pfb_pkg::PFB_OP_ACC_PROG)
          begin
            state <= ST_BUSY;
            cnt   <= BUSY_CYC;
          end
          else
            state <= ST_IDLE;
        end
        ST_BUSY:
        begin
          // high supply is held until the embedded program reports done
          if (cnt != pfb_pkg::CNT_ZERO)
            cnt <= cnt - CNT_ONE_L;
          else if (rdy_sync)
            state <= ST_IDLE;
        end
        ST_RD_WAIT:
        begin
          cnt <= cnt - CNT_ONE_L;
          if (cnt_done)
            state <= ST_IDLE;
        end
        ST_RST_LOW:
        begin
          cnt <= cnt - CNT_ONE_L;
          if (cnt_done)
          begin
            state <= ST_RST_WAIT;
            cnt   <= RST_READ_CYC;
          end
        end
        ST_RST_WAIT:
        begin
          // settle time differs with busy state, so wait on the indicator too
          if (cnt != pfb_pkg::CNT_ZERO)
            cnt <= cnt - CNT_ONE_L;
          else if (rdy_sync)
            state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pins_out.addr                <= '0;
      pins_out.dq                  <= '0;
      pins_out.dq_oe_n             <= 1'b1;
      pins_out.select_n            <= 1'b1;
      pins_out.out_gate_n          <= 1'b1;
      pins_out.write_n             <= 1'b1;
      pins_out.reset_n             <= 1'b1;
      pins_out.fast_program_supply <= 1'b0;
    end
    else
    begin
      pins_out.addr                <= cur.addr;
      pins_out.dq                  <= (cur.op == pfb_pkg::PFB_OP_ACC_PROG && !beat)
                                      ? pfb_pkg::SHORTCUT_PROG_CMD : cur.data;
      pins_out.dq_oe_n             <= !(state inside {ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD});
      pins_out.select_n            <= !(state inside {ST_WR_SETUP, ST_WR_PULSE, ST_WR_HOLD,
                                                      ST_RD_WAIT});
      pins_out.out_gate_n          <= (state != ST_RD_WAIT);
      pins_out.write_n             <= (state != ST_WR_PULSE);
      pins_out.reset_n             <= (state != ST_RST_LOW);
      pins_out.fast_program_supply <= (cur.op == pfb_pkg::PFB_OP_ACC_PROG) &&
                                      (state inside {ST_ACC_RAMP, ST_WR_SETUP, ST_WR_PULSE,
                                                     ST_WR_HOLD, ST_BUSY});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // answers and flags
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      resp_valid_out <= 1'b0;
      resp_data_out  <= '0;
      sector_out     <= '0;
    end
    else
    begin
      resp_valid_out <= (state == ST_RD_WAIT) && cnt_done;
      if ((state == ST_RD_WAIT) && cnt_done)
        resp_data_out <= dq_sync;
      if (accept)
        sector_out <= pfb_pkg::sector_of(req_in.addr);
    end
  end

  // an aborted program or erase must be reissued by the requester
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      restart_needed_out <= 1'b0;
    else if (accept && req_in.op == pfb_pkg::PFB_OP_RESET && !rdy_sync)
      restart_needed_out <= 1'b1;
    else if (accept && req_in.op != pfb_pkg::PFB_OP_READ)
      restart_needed_out <= 1'b0;
  end

endmodule

//--- tb/pfb_host_monitor.sv
// concurrent checks on the flash host controller ports
module pfb_host_monitor (
  // watched ports
  input wire logic                       clk_in,
  input wire logic                       rst_in,
  input wire logic                       req_valid_in,
  input wire pfb_pkg::pfb_req_s          req_in,
  input wire logic                       req_ready_out,
  input wire logic                       resp_valid_out,
  input wire logic [pfb_pkg::SECT_W-1:0] sector_out,
  input wire pfb_pkg::pfb_pins_s         pins_out,
  input wire logic                       done_indicator_n_in,
  input wire logic                       device_busy_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  wire pfb_pkg::pfb_pins_s p = pins_out;
  wire logic take = req_valid_in && req_ready_out;
  ////////////////////////////////////////////////////////////
  property p_wr; !p.write_n |-> !p.select_n && p.out_gate_n && !p.dq_oe_n; endproperty
  a_wr: assert property (p_wr) else $error("bad write cycle");
  property p_gate; !p.out_gate_n |-> p.dq_oe_n && p.write_n; endproperty
  a_gate: assert property (p_gate) else $error("host drives data while gated");
  property p_acc; p.fast_program_supply |-> p.out_gate_n && p.reset_n; endproperty
  a_acc: assert property (p_acc) else $error("supply high outside program");
  property p_rpw; $fell(p.reset_n) |-> !p.reset_n [*5]; endproperty
  a_rpw: assert property (p_rpw) else $error("reset pulse short");
  property p_rtr; $rose(p.reset_n) |-> p.select_n [*2]; endproperty
  a_rtr: assert property (p_rtr) else $error("read too soon after reset");
  // the previous read's pulse may still stand on the take edge
  property p_rdl;
    take && req_in.op == pfb_pkg::PFB_OP_READ |=> !resp_valid_out [*4] ##1 resp_valid_out;
  endproperty
  a_rdl: assert property (p_rdl) else $error("read answer late or early");
  property p_sec; take |=> sector_out == $past(req_in.addr[21:15]); endproperty
  a_sec: assert property (p_sec) else $error("sector decode wrong");
  property p_bsy; device_busy_out == !$past(done_indicator_n_in, 2); endproperty
  a_bsy: assert property (p_bsy) else $error("busy flag out of step");
endmodule
bind pfb_host pfb_host_monitor i_pfb_host_monitor (.clk_in(clk_in), .rst_in(rst_in),
  .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
  .resp_valid_out(resp_valid_out), .sector_out(sector_out), .pins_out(pins_out),
  .done_indicator_n_in(done_indicator_n_in), .device_busy_out(device_busy_out));

//--- tb/pfb_flash_model.sv
// behavioural flash device driven by the host pins
module pfb_flash_model #(
  parameter int         PROG_CYC = 12,
  parameter int         SETTLE   = 6,
  parameter logic [7:0] ID_CODE  = 8'h5A // arbitrary value
) (
  // clock only steps the model; pins
  input  wire logic               clk_in,
  input  wire pfb_pkg::pfb_pins_s pins_in,
  output logic [15:0]             dq_out,
  output logic                    done_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [logic [21:0]];
  logic [21:0] pa;
  logic [15:0] pd;
  logic        byp = 1'b0, arm = 1'b0, idm = 1'b0, we_q = 1'b1, pend = 1'b0, tog = 1'b0;
  int          busy = 0;
  wire pfb_pkg::pfb_pins_s p = pins_in;
  wire logic   wr = !we_q && p.write_n && !p.select_n && p.out_gate_n && p.reset_n;
  assign done_n_out = (busy == 0);
  ////////////////////////////////////////////////////////////
  always @(posedge clk_in)
  begin
    we_q <= p.write_n;
    tog <= ~tog;
    if (!p.reset_n)
    begin
      byp <= 1'b0;
      arm <= 1'b0;
      idm <= 1'b0;
      pend <= 1'b0;
      busy <= (busy > 0) ? SETTLE : 0;
    end
    else if (busy > 0)
    begin
      busy <= busy - 1;
      pend <= pend && busy > 1;
      if (pend && busy == 1)
        mem[pa] = pd;
    end
    else if (wr)
    begin
      arm <= !arm && p.dq == 16'h00A0 && (byp || p.fast_program_supply);
      byp <= byp || p.dq == 16'h0020;
      idm <= idm || p.dq == 16'h0090;
      if (arm)
      begin
        pa <= p.addr;
        pd <= p.dq;
        pend <= 1'b1;
        busy <= PROG_CYC;
      end
      else if (p.dq == 16'h0030 || p.dq == 16'h0010)
      begin
        foreach (mem[k])
          if (!p.dq[5] || k[21:15] == p.addr[21:15])
            mem[k] = 16'hFFFF;
        busy <= PROG_CYC;
      end
    end
  end
  // released lines toggle so a stale word can never pass
  always @(p or idm or busy or tog)
    if (!p.select_n && !p.out_gate_n && p.reset_n)
      dq_out = idm ? {8'h00, ID_CODE} : (mem.exists(p.addr) ? mem[p.addr] : 16'hFFFF);
    else
      dq_out = {8{tog, ~tog}};
endmodule

//--- tb/tb.sv
// self-checking bench: host controller against the flash model
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0]       ID = 8'h5A; // arbitrary value
  localparam pfb_pkg::pfb_op_e RD = pfb_pkg::PFB_OP_READ;
  localparam pfb_pkg::pfb_op_e WR = pfb_pkg::PFB_OP_WRITE;
  localparam pfb_pkg::pfb_op_e AP = pfb_pkg::PFB_OP_ACC_PROG;
  localparam pfb_pkg::pfb_op_e RS = pfb_pkg::PFB_OP_RESET;
  logic               clk_in = 1'b0;
  logic               rst_in = 1'b1;
  logic               req_valid_in = 1'b0;
  pfb_pkg::pfb_req_s  req_in = '0;
  logic               req_ready_out, resp_valid_out, restart_needed_out, device_busy_out;
  logic               done_indicator_n_in;
  logic [15:0]        resp_data_out, dq_in;
  logic [6:0]         sector_out;
  pfb_pkg::pfb_pins_s pins_out;
  int                 err_total = 0;
  int                 comparisons = 0;
  int                 cycles = 0;
  always #50 clk_in = ~clk_in;
  pfb_host i_pfb_host (.clk_in(clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
    .req_in(req_in), .req_ready_out(req_ready_out), .resp_valid_out(resp_valid_out),
    .resp_data_out(resp_data_out), .restart_needed_out(restart_needed_out),
    .device_busy_out(device_busy_out), .sector_out(sector_out), .pins_out(pins_out),
    .dq_in(dq_in), .done_indicator_n_in(done_indicator_n_in));
  pfb_flash_model #(.ID_CODE(ID)) i_pfb_flash_model (.clk_in(clk_in), .pins_in(pins_out),
    .dq_out(dq_in), .done_n_out(done_indicator_n_in));
  ////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic req(input pfb_pkg::pfb_op_e op, input logic [21:0] a, input logic [15:0] d);
    @(negedge clk_in);
    req_valid_in = 1'b1;
    req_in = '{op, a, d};
    while (req_ready_out !== 1'b1)
      @(negedge clk_in);
    @(negedge clk_in);
    req_valid_in = 1'b0;
  endtask
  task automatic rd(input logic [21:0] a, input logic [15:0] exp, input string what);
    req(RD, a, 16'h0000);
    for (int n = 0; n < 20 && resp_valid_out !== 1'b1; n++)
      @(negedge clk_in);
    chk(what, exp, resp_data_out);
  endtask
  // waits for the synced busy flag to reach a level
  task automatic wait_busy(input logic lvl);
    for (int n = 0; n < 100 && device_busy_out !== lvl; n++)
      @(negedge clk_in);
    chk("busy flag", {15'h0, lvl}, {15'h0, device_busy_out});
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_accel();
    req(AP, 22'h0ABCDE, 16'h1234);
    rd(22'h0ABCDE, 16'h1234, "accel word");
    chk("sector", 16'h0015, {9'h000, sector_out});
    rd(22'h3F8001, 16'hFFFF, "top blank");
    chk("top sector", 16'h007F, {9'h000, sector_out});
  endtask
  task automatic t_ident();
    req(WR, 22'h000000, 16'h0090);
    rd(22'h0ABCDE, {8'h00, ID}, "ident code");
    req(RS, 22'h000000, 16'h0000);
    chk("restart idle", 16'h0000, {15'h0, restart_needed_out});
    rd(22'h0ABCDE, 16'h1234, "array after reset");
  endtask
  task automatic t_short();
    req(WR, 22'h000000, 16'h0020);
    req(WR, 22'h008000, 16'h00A0);
    req(WR, 22'h008000, 16'hBEEF);
    wait_busy(1'b1);
    wait_busy(1'b0);
    rd(22'h008000, 16'hBEEF, "shortcut word");
    req(WR, 22'h008001, 16'h00A0);
    req(WR, 22'h008001, 16'hCAFE);
    wait_busy(1'b1);
    req(RS, 22'h000000, 16'h0000);
    chk("restart busy", 16'h0001, {15'h0, restart_needed_out});
    rd(22'h008001, 16'hFFFF, "aborted word");
    req(WR, 22'h008002, 16'h00A0);
    req(WR, 22'h008002, 16'h5555);
    chk("restart cleared", 16'h0000, {15'h0, restart_needed_out});
    rd(22'h008002, 16'hFFFF, "mode left");
    req(AP, 22'h008001, 16'hCAFE);
    rd(22'h008001, 16'hCAFE, "reissued word");
  endtask
  task automatic t_erase();
    req(WR, 22'h0ABCDE, 16'h0030);
    wait_busy(1'b1);
    wait_busy(1'b0);
    rd(22'h0ABCDE, 16'hFFFF, "sector erased");
    rd(22'h008000, 16'hBEEF, "other sector");
  endtask
  ////////////////////////////////////////////////////////////
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      err_total++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    t_accel();
    t_ident();
    t_short();
    t_erase();
    wrap_up();
  end
endmodule
